//--- hw/usb_pin_control.v
`timescale 1ns/100ps
`include "usb_pin_ctl_defs.vh"

//Contract
//- pullup on when connect and power-gate allows
//- gate set, no bus power: pullup off
//- chip reset spares pin cfg, link ctl
//- irq disabled holds output at inactive level
//- irq inactive after power-up and chip reset
//- level mode: open-drain low when flag set
//- level mode releases after last flag cleared
//- polarity ignored in level mode
//- edge mode pulses on new or remaining
//- edge polarity selects rising or falling edges
//- input levels read at bits 7..4
//- bits 3..0 drive outputs, read back stored
//- status mux selects ready, power, traffic, frame
//- ready rises after reset, default selection
//- traffic sets on sync, clears reset/idle
//- frame mode square wave rising at frame
//- bus power loss sets interrupt flag
//- logic clocked on single reference edge
module usb_pin_control #(
    parameter IDLE_CYCLES = `IDLE_CYCLES,
    parameter PULSE_CYCLES = `IRQ_PULSE_CYCLES,
    parameter READY_CYCLES = `READY_DELAY_CYCLES
)
(
    input wire mclk,
    input wire srst,
    input wire chipResetN,
    input wire regWrite,
    input wire [4:0] regAddr,
    input wire [7:0] regWdata,
    output reg [7:0] regRdata,
    input wire busPowerSense,
    input wire [3:0] genInputs,
    input wire [7:0] eventSet,
    input wire syncDetect,
    input wire busResetDet,
    input wire lineIdleJ,
    input wire frameStart,
    output reg pullupOn,
    output reg irqOut,
    output reg irqOe,
    output reg [3:0] genOutputs,
    output reg auxStatusOut
);

    wire chipResetSync;
    wire pwrSync;
    wire [3:0] genInSync;
    reg [7:0] linkCtl_q;
    reg [7:0] host_cpu_control_reg_q;
    reg [7:0] pinCfg_q;
    reg [7:0] flags_q;
    reg [7:0] flags_d;
    reg [7:0] mask_q;
    reg [3:0] genOut_q;
    reg pwrPrev_q;
    reg [7:0] pendPrev_q;
    reg [7:0] pulseCnt_q;
    reg [7:0] readyCnt_q;
    reg ready_q;
    reg traffic_q;
    reg [7:0] idleCnt_q;
    reg frameWave_q;
    reg [7:0] frameCnt_q;
    wire coreRst;
    wire [7:0] pending;
    wire anyPend;
    wire newReq;
    wire clearedLeft;
    wire gateOk;
    wire levelMode;
    wire polHigh;
    wire irqEn;

    // external pins pass the three-stage synchroniser
    sync3 #(.WIDTH(6)) pinSync (
        .mclk(mclk),
        .din({chipResetN, busPowerSense, genInputs}),
        .dout({chipResetSync, pwrSync, genInSync})
    );

    // chip reset scope: everything but link and pin config
    assign coreRst = srst | ~chipResetSync;
    assign pending = flags_q & mask_q;
    assign anyPend = |pending;
    assign newReq = |(pending & ~pendPrev_q);
    assign clearedLeft = (|(pendPrev_q & ~pending)) & anyPend;
    assign levelMode = pinCfg_q[`PIN_LEVEL_BIT];
    assign polHigh = pinCfg_q[`PIN_POL_BIT];
    assign irqEn = host_cpu_control_reg_q[`CPU_IRQ_EN_BIT];
    assign gateOk = ~linkCtl_q[`LINK_PWR_GATE_BIT] | pwrSync;

    // registers spared by chip reset, cleared only by srst
    always @(posedge mclk)
    begin
        if (srst)
        begin
            linkCtl_q <= `LINK_CTL_RESET;
            pinCfg_q <= `PIN_CFG_RESET;
        end
        else if (regWrite)
        begin
            if (regAddr == `REG_LINK_CTL)
                linkCtl_q <= regWdata;
            if (regAddr == `REG_PIN_CFG)
                pinCfg_q <= regWdata;
        end
    end

    // interrupt flags: hardware set wins over write-one clear
    always @*
    begin
        flags_d = flags_q;
        if (regWrite && regAddr == `REG_IRQ_FLAGS)
            flags_d = flags_d & ~regWdata;
        flags_d = flags_d | eventSet;
        if (pwrPrev_q && !pwrSync)
            flags_d[`FLAG_PWR_LOST_BIT] = 1'b1;
    end

    // registers reset by chip reset
    always @(posedge mclk)
    begin
        if (coreRst)
        begin
            host_cpu_control_reg_q <= `CPU_CTL_RESET;
            flags_q <= `FLAG_RESET;
            mask_q <= `MASK_RESET;
            genOut_q <= `GEN_OUT_RESET;
            pwrPrev_q <= 1'b0;
            pendPrev_q <= 8'h00;
        end
        else
        begin
            flags_q <= flags_d;
            pwrPrev_q <= pwrSync;
            pendPrev_q <= pending;
            if (regWrite && regAddr == `REG_CPU_CTL)
                host_cpu_control_reg_q <= regWdata;
            if (regWrite && regAddr == `REG_IRQ_MASK)
                mask_q <= regWdata;
            if (regWrite && regAddr == `REG_GEN_IO)
                genOut_q <= regWdata[3:0];
        end
    end

    // read mux
    always @(posedge mclk)
    begin
        if (srst)
            regRdata <= 8'h00;
        else
        begin
            case (regAddr)
                `REG_LINK_CTL: regRdata <= linkCtl_q;
                `REG_CPU_CTL: regRdata <= host_cpu_control_reg_q;
                `REG_PIN_CFG: regRdata <= pinCfg_q;
                `REG_IRQ_FLAGS: regRdata <= flags_q;
                `REG_IRQ_MASK: regRdata <= mask_q;
                `REG_GEN_IO: regRdata <= {genInSync, genOut_q};
                default: regRdata <= 8'h00;
            endcase
        end
    end

    // edge-mode pulse timer
    always @(posedge mclk)
    begin
        if (coreRst || !irqEn || levelMode)
            pulseCnt_q <= 8'h00;
        else if (newReq || clearedLeft)
            pulseCnt_q <= PULSE_CYCLES[7:0];
        else if (pulseCnt_q != 8'h00)
            pulseCnt_q <= pulseCnt_q - 8'h01;
    end

    // interrupt pin drive; chip reset keeps edge mode driven at its inactive level
    always @(posedge mclk)
    begin
        if (srst)
        begin
            irqOut <= 1'b1;
            irqOe <= 1'b0;
        end
        else if (!chipResetSync)
        begin
            irqOut <= ~levelMode & ~polHigh;
            irqOe <= ~levelMode; // level mode released, edge mode driven inactive
        end
        else if (levelMode)
        begin
            irqOut <= 1'b0;
            irqOe <= irqEn & anyPend;
        end
        else
        begin
            irqOe <= 1'b1;
            if (irqEn && pulseCnt_q != 8'h00)
                irqOut <= polHigh;
            else
                irqOut <= ~polHigh;
        end
    end

    // pullup and general outputs
    always @(posedge mclk)
    begin
        if (srst)
        begin
            pullupOn <= 1'b0;
            genOutputs <= `GEN_OUT_RESET;
        end
        else
        begin
            pullupOn <= linkCtl_q[`LINK_CONNECT_BIT] & gateOk;
            genOutputs <= genOut_q;
        end
    end

    // ready-after-reset delay
    always @(posedge mclk)
    begin
        if (coreRst)
        begin
            readyCnt_q <= 8'h00;
            ready_q <= 1'b0;
        end
        else if (readyCnt_q == READY_CYCLES[7:0])
            ready_q <= 1'b1;
        else
            readyCnt_q <= readyCnt_q + 8'h01;
    end

    // traffic indicator
    always @(posedge mclk)
    begin
        if (coreRst || busResetDet)
        begin
            traffic_q <= 1'b0;
            idleCnt_q <= 8'h00;
        end
        else if (syncDetect)
        begin
            traffic_q <= 1'b1;
            idleCnt_q <= 8'h00;
        end
        else if (lineIdleJ)
        begin
            if (idleCnt_q == IDLE_CYCLES[7:0] - 8'h01)
                traffic_q <= 1'b0;
            else
                idleCnt_q <= idleCnt_q + 8'h01;
        end
        else
            idleCnt_q <= 8'h00;
    end

    // frame square wave: high for 256 cycles, then low until next frame
    always @(posedge mclk)
    begin
        if (coreRst)
        begin
            frameWave_q <= 1'b0;
            frameCnt_q <= 8'h00;
        end
        else if (frameStart)
        begin
            frameWave_q <= 1'b1;
            frameCnt_q <= 8'h00;
        end
        else if (frameCnt_q == 8'hff)
            frameWave_q <= 1'b0;
        else
            frameCnt_q <= frameCnt_q + 8'h01;
    end

    // status output multiplexer
    always @(posedge mclk)
    begin
        if (srst)
            auxStatusOut <= 1'b0;
        else
        begin
            case ({pinCfg_q[`PIN_SEL_HI_BIT], pinCfg_q[`PIN_SEL_LO_BIT]})
                `AUX_READY: auxStatusOut <= ready_q;
                `AUX_PWR: auxStatusOut <= pwrSync;
                `AUX_TRAFFIC: auxStatusOut <= traffic_q;
                `AUX_FRAME: auxStatusOut <= frameWave_q;
                default: auxStatusOut <= 1'b0;
            endcase
        end
    end

endmodule // usb_pin_control

//--- inc/usb_pin_ctl_defs.vh
`ifndef USB_PIN_CTL_DEFS_VH
`define USB_PIN_CTL_DEFS_VH

// register indices on the internal register port
`define REG_LINK_CTL 5'h0f
`define REG_CPU_CTL 5'h10
`define REG_PIN_CFG 5'h11
`define REG_GEN_IO 5'h14
`define REG_IRQ_FLAGS 5'h0d
`define REG_IRQ_MASK 5'h0e

// link control fields
`define LINK_CONNECT_BIT 3
`define LINK_PWR_GATE_BIT 6
`define LINK_CTL_RESET 8'h00

// cpu control fields
`define CPU_IRQ_EN_BIT 0
`define CPU_CTL_RESET 8'h00

// pin config fields
`define PIN_SEL_LO_BIT 0
`define PIN_SEL_HI_BIT 1
`define PIN_POL_BIT 2
`define PIN_LEVEL_BIT 3
`define PIN_CFG_RESET 8'h00

// interrupt flag positions
`define FLAG_PWR_LOST_BIT 5
`define FLAG_RESET 8'h00
`define MASK_RESET 8'h00

// general outputs
`define GEN_OUT_RESET 4'h0

// timing
`define REF_CLK_HZ 12000000
`define USB_BIT_HZ 12000000
`define IDLE_BITS 32
`define IDLE_CYCLES ((`IDLE_BITS * `REF_CLK_HZ) / `USB_BIT_HZ)
`define IRQ_PULSE_CYCLES 4
`define READY_DELAY_CYCLES 8

// status output select codes
`define AUX_READY 2'b00
`define AUX_PWR 2'b01
`define AUX_TRAFFIC 2'b10
`define AUX_FRAME 2'b11

`endif

//--- hw/sync3.v
`timescale 1ns/100ps
`include "usb_pin_ctl_defs.vh"

module sync3 #(
    parameter WIDTH = 1
)
(
    input wire mclk,
    input wire [WIDTH-1:0] din,
    output reg [WIDTH-1:0] dout
);

    reg [WIDTH-1:0] s1_q;
    reg [WIDTH-1:0] s2_q;
    reg [WIDTH-1:0] s3_q;

    // three stages; output follows once stages two and three agree
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : bitSync
            always @(posedge mclk)
            begin
                s1_q[i] <= din[i];
                s2_q[i] <= s1_q[i];
                s3_q[i] <= s2_q[i];
                if (s2_q[i] == s3_q[i])
                    dout[i] <= s3_q[i];
            end
        end
    endgenerate

endmodule // sync3

//--- bench/irq_pin_model.sv
`timescale 1ns/100ps
module irq_pin_model
(
    input logic irqOut,
    input logic irqOe,
    output logic irqPin
);
    // board pull-up on the shared interrupt line
    assign irqPin = irqOe ? irqOut : 1'b1;
endmodule // irq_pin_model

//--- bench/usb_pin_control_checker.sv
`timescale 1ns/100ps
module usb_pin_control_checker #(parameter IDLE_CYCLES = 32, parameter PULSE_CYCLES = 4, parameter READY_CYCLES = 8)
(
    input logic mclk,
    input logic srst,
    input logic regWrite,
    input logic [4:0] regAddr,
    input logic [7:0] regWdata,
    input logic busPowerSense,
    input logic syncDetect,
    input logic pullupOn,
    input logic irqOut,
    input logic irqOe,
    input logic [3:0] genOutputs,
    input logic auxStatusOut
);
    logic [7:0] pc_q;
    logic [5:0] sh_q;
    logic wl;
    // pin config shadow and sense history
    always_ff @(posedge mclk)
    begin
        if (srst)
            pc_q <= 8'h00;
        else if (regWrite && regAddr == 5'h11)
            pc_q <= regWdata;
        sh_q <= {sh_q[4:0], busPowerSense};
    end
    assign wl = regWrite && regAddr == 5'h0f;
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    chk_pullup_conn: assert property (wl && !regWdata[6] |-> ##2 pullupOn == $past(regWdata[3], 2))
        else $error("pullup");
    chk_pullup_gate: assert property (wl && regWdata[6] && sh_q == 6'h00 && !busPowerSense |-> ##2 !pullupOn)
        else $error("gate");
    chk_reset_idle: assert property (disable iff (1'b0) srst |=> irqOut && !irqOe && !pullupOn)
        else $error("reset");
    chk_genout_write: assert property (regWrite && regAddr == 5'h14 |-> ##2 genOutputs == $past(regWdata[3:0], 2))
        else $error("genout");
    chk_edge_pulse: assert property (!pc_q[3] && irqOe && irqOut == pc_q[2] && $past(irqOut) != pc_q[2]
        |-> (irqOut == pc_q[2])[*4] ##1 irqOut != pc_q[2])
        else $error("pulse");
    chk_level_low: assert property (pc_q[3] && $past(pc_q[3]) |-> !irqOut)
        else $error("level");
    chk_aux_power: assert property (pc_q[1:0] == 2'b01 && $past(pc_q[1:0]) == 2'b01 && sh_q == {6{sh_q[0]}}
        |-> auxStatusOut == sh_q[0])
        else $error("aux");
    chk_traffic_set: assert property (pc_q[1:0] == 2'b10 && $past(pc_q[1:0]) == 2'b10 && syncDetect
        |-> ##[1:3] auxStatusOut)
        else $error("traffic");
    cover property (wl && regWdata[3]);
    cover property (pc_q[3] && irqOe);
    cover property (!pc_q[3] && irqOut && pc_q[2]);
endmodule // usb_pin_control_checker
bind usb_pin_control usb_pin_control_checker #(.IDLE_CYCLES(IDLE_CYCLES), .PULSE_CYCLES(PULSE_CYCLES),
    .READY_CYCLES(READY_CYCLES)) u_chk (.mclk, .srst, .regWrite, .regAddr, .regWdata, .busPowerSense,
    .syncDetect, .pullupOn, .irqOut, .irqOe, .genOutputs, .auxStatusOut);

//--- bench/usb_pin_control_tb_top.sv
`timescale 1ns/100ps
module usb_pin_control_tb_top;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic chipResetN = 1'b1;
    logic regWrite = 1'b0;
    logic [4:0] regAddr = 5'h00;
    logic [7:0] regWdata = 8'h00;
    logic busPowerSense = 1'b0;
    logic [3:0] genInputs = 4'h0;
    logic [7:0] eventSet = 8'h00;
    logic syncDetect = 1'b0;
    logic busResetDet = 1'b0;
    logic lineIdleJ = 1'b0;
    logic frameStart = 1'b0;
    wire [7:0] regRdata;
    wire pullupOn, irqOut, irqOe, auxStatusOut, irqPin;
    wire [3:0] genOutputs;
    wire [39:0] obs = {7'h00, auxStatusOut, 4'h0, genOutputs, 7'h00, irqPin, 7'h00, pullupOn, regRdata};
    logic [11:0] noteQ[$];
    logic [11:0] n;
    logic [7:0] d;
    int num_errors = 0;
    int compares = 0;
    initial forever #25 mclk = ~mclk;
    usb_pin_control u_usb_pin_control (.mclk, .srst, .chipResetN, .regWrite, .regAddr, .regWdata, .regRdata,
        .busPowerSense, .genInputs, .eventSet, .syncDetect, .busResetDet, .lineIdleJ, .frameStart, .pullupOn,
        .irqOut, .irqOe, .genOutputs, .auxStatusOut);
    irq_pin_model u_irq_pin_model (.irqOut, .irqOe, .irqPin);
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
    endtask
    task automatic note(input logic [3:0] c, input logic [7:0] v);
        noteQ.push_back({c, v});
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= v;
        tick(1);
        regWrite <= 1'b0;
        tick(1);
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] v);
        regAddr <= a;
        tick(2);
        note(0, v);
    endtask
    task automatic pulse(input logic [7:0] e);
        eventSet <= e;
        tick(1);
        eventSet <= 8'h00;
        tick(2);
    endtask
    // settled outputs against the oldest notes
    always @(negedge mclk)
        while (noteQ.size() > 0)
        begin
            n = noteQ.pop_front();
            check(obs[n[11:8] * 8 +: 8], n[7:0]);
        end
    // watchdog
    initial
    begin
        #3000000;
        num_errors++;
        end_sim();
    end
    // main sequence
    initial
    begin
        void'($urandom(70478));
        tick(2);
        srst <= 1'b0;
        tick(1);
        note(2, 8'h01);
        note(4, 8'h00);
        for (int i = 0; i < 20 && auxStatusOut !== 1'b1; i++)
            tick(1);
        if (auxStatusOut !== 1'b1)
        begin
            num_errors++;
            end_sim();
        end
        $display("reset done");
        for (int i = 0; i < 8; i++)
        begin
            busPowerSense <= i[2];
            tick(6);
            wr(5'h0f, {1'b0, i[1], 2'b00, i[0], 3'b000});
            tick(1);
            note(1, {7'h00, i[0] && (!i[1] || i[2])});
        end
        $display("pullup done");
        repeat (4)
        begin
            d = $urandom;
            genInputs <= d[7:4];
            tick(2);
            wr(5'h14, {~d[7:4], d[3:0]});
            tick(1);
            note(3, {4'h0, d[3:0]});
            rd(5'h14, d);
        end
        rd(5'h1f, 8'h00);
        $display("gpio done");
        wr(5'h11, 8'h01);
        busPowerSense <= 1'b0;
        tick(8);
        note(4, 8'h00);
        wr(5'h11, 8'h02);
        syncDetect <= 1'b1;
        pulse(8'h00);
        syncDetect <= 1'b0;
        note(4, 8'h01);
        lineIdleJ <= 1'b1;
        tick(40);
        note(4, 8'h00);
        // bus reset clears the indicator long before the idle count would
        syncDetect <= 1'b1;
        tick(1);
        syncDetect <= 1'b0;
        busResetDet <= 1'b1;
        tick(1);
        busResetDet <= 1'b0;
        tick(2);
        note(4, 8'h00);
        wr(5'h11, 8'h03);
        frameStart <= 1'b1;
        pulse(8'h00);
        frameStart <= 1'b0;
        note(4, 8'h01);
        busPowerSense <= 1'b1;
        $display("status done");
        rd(5'h0d, 8'h20);
        wr(5'h0e, 8'hff);
        wr(5'h0d, 8'hff);
        wr(5'h11, 8'h00);
        pulse(8'h01);
        note(2, 8'h01);
        wr(5'h0d, 8'hff);
        wr(5'h10, 8'h01);
        wr(5'h11, 8'h0c);
        pulse(8'h03);
        note(2, 8'h00);
        wr(5'h0d, 8'h01);
        tick(2);
        note(2, 8'h00);
        wr(5'h0d, 8'h02);
        tick(2);
        note(2, 8'h01);
        wr(5'h11, 8'h04);
        tick(1);
        note(2, 8'h00);
        pulse(8'h04);
        note(2, 8'h01);
        tick(6);
        note(2, 8'h00);
        // clearing one request while another stays pending gives a fresh edge
        pulse(8'h08);
        tick(6);
        wr(5'h0d, 8'h08);
        tick(1);
        note(2, 8'h01);
        tick(6);
        $display("irq done");
        wr(5'h14, 8'h0f);
        chipResetN <= 1'b0;
        tick(8);
        chipResetN <= 1'b1;
        tick(2);
        note(1, 8'h01);
        note(3, 8'h00);
        note(2, 8'h00);
        rd(5'h11, 8'h04);
        rd(5'h10, 8'h00);
        $display("chip reset done");
        tick(2);
        end_sim();
    end
endmodule // usb_pin_control_tb_top
